// >>> logic/s3ct_pkg.sv
// constants for the sinc3 conversion-timing sequencer
// assumes a single clock domain; counts are in modulator periods

package s3ct_pkg;

  // one modulator period is this many adc clock periods
  localparam int unsigned MOD_DIV = 16;
  localparam int unsigned MOD_CNT_W = 4;

  // start delay after a conversion start, in modulator periods
  localparam int unsigned DELAY_W = 3;
  localparam logic [2:0] DELAY_SEL_RST = 3'h0;
  localparam logic [12:0] DELAY_TAB [0:7] = '{
    13'h000E, 13'h0019, 13'h0040, 13'h0100,
    13'h0400, 13'h0800, 13'h1000, 13'h0001
  };

  // sinc3 drops this many unsettled outputs after each start
  localparam logic [1:0] SINC3_SUPPRESS = 2'h2;

  // filter select codes
  localparam logic FILT_SINC3 = 1'h0;
  localparam logic FILT_LOWLAT = 1'h1;

  // conversion mode codes
  localparam logic MODE_CONT = 1'h0;
  localparam logic MODE_SINGLE = 1'h1;

  // rate codes 0..13 map 2.5 SPS .. 4000 SPS; above 13 clamps to 13
  localparam int unsigned RATE_W = 4;
  localparam logic [3:0] RATE_MAX = 4'hD;
  localparam int unsigned RATE_N = 14;
  localparam int unsigned CNT_W = 19;
  localparam int unsigned PER_W = 17;

  // steady-state result spacing per rate, modulator periods
  localparam logic [16:0] PERIOD_TAB [0:13] = '{
    17'h19000, 17'h0C800, 17'h06400, 17'h03C00, 17'h03200,
    17'h01400, 17'h010A8, 17'h00A00, 17'h00500, 17'h00280,
    17'h00140, 17'h00100, 17'h00080, 17'h00040
  };

  // first-result latency, sinc3 rates first then low-latency rates
  localparam logic [18:0] FIRST_TAB [0:27] = '{
    19'h4B041, 19'h25841, 19'h12C41, 19'h0B441, 19'h09641,
    19'h03C41, 19'h03239, 19'h01E41, 19'h00F41, 19'h007C1,
    19'h00401, 19'h00328, 19'h001A8, 19'h000E8,
    19'h19681, 19'h0CE81, 19'h06A81, 19'h03C41, 19'h03881,
    19'h01428, 19'h010E9, 19'h00A28, 19'h00528, 19'h002A8,
    19'h00168, 19'h00128, 19'h000A8, 19'h00068
  };

  typedef enum logic [1:0] {
    S3CT_IDLE,
    S3CT_DELAY,
    S3CT_SAMPLE,
    S3CT_OVERHEAD
  } s3ct_state_t;

endpackage

// >>> logic/s3ct_rate_rom.sv
// rate lookup: first-result latency and result spacing per rate
// read data is registered, one clock after the index
`timescale 1ns/1ps

module s3ct_rate_rom
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic filt_sel,
  input wire logic [3:0] rate_idx,
  output logic [18:0] first_r,
  output logic [16:0] period_r
);

  logic [4:0] first_idx;

  // low-latency entries follow the fourteen sinc3 entries
  assign first_idx = filt_sel ? 5'(rate_idx) + 5'h0E : 5'(rate_idx);

  // registered read port
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_r <= 19'h00000;
      period_r <= 17'h00000;
    end
    else
    begin
      first_r <= s3ct_pkg::FIRST_TAB[first_idx];
      period_r <= s3ct_pkg::PERIOD_TAB[rate_idx];
    end
  end

endmodule

// >>> logic/s3ct_seq.sv
// conversion-timing sequencer for the sinc3 decimation filter
// assumes all inputs synchronous to clk; adc_tick is one pulse per
// adc clock period; start_cmd is the pulse of a decoded start frame
`timescale 1ns/1ps

module s3ct_seq
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adc_tick,
  input wire logic start_pin,
  input wire logic start_cmd,
  input wire logic stop_cmd,
  input wire logic conv_mode,
  input wire logic filt_sel,
  input wire logic [3:0] data_rate,
  input wire logic [2:0] delay_sel,
  output logic busy_r,
  output logic sampling_r,
  output logic compensating_r,
  output logic filt_out_r,
  output logic new_data_r,
  output logic sinc3_active_r
);

  // true on the modulator tick that ends a count
  function automatic logic count_done(input logic [18:0] cnt,
                                      input logic tick);
    count_done = tick && (cnt == 19'h00001);
  endfunction

  s3ct_pkg::s3ct_state_t state_r;
  s3ct_pkg::s3ct_state_t state_nxt;
  logic [18:0] cnt_r;
  logic [18:0] cnt_nxt;
  logic [3:0] div_r;
  logic [3:0] div_nxt;
  logic [1:0] sup_r;
  logic [1:0] sup_nxt;
  logic first_r;
  logic first_nxt;
  logic pin_q_r;
  logic cfg_mode_r;
  logic cfg_filt_r;
  logic [3:0] cfg_rate_r;
  logic [18:0] rom_first;
  logic [16:0] rom_period;
  logic start_evt;
  logic mod_tick;
  logic [3:0] rate_clamped;
  logic [1:0] sup_limit;
  logic [18:0] delay_cnt;
  logic [18:0] period_cnt;
  logic [18:0] settle_cnt;
  logic [18:0] ovh_cnt;
  logic done;
  logic filt_evt;
  logic deliver;

  // a start event from the pin edge or from the command frame
  assign start_evt = (start_pin && !pin_q_r) || start_cmd;

  // modulator tick every sixteenth adc clock, so all timing
  // follows the adc clock rather than clk
  assign mod_tick = adc_tick &&
    (div_r == 4'(s3ct_pkg::MOD_DIV - 1));

  // unused rate codes fall back to the fastest rate
  assign rate_clamped = (cfg_rate_r > s3ct_pkg::RATE_MAX) ?
    s3ct_pkg::RATE_MAX : cfg_rate_r;

  // sinc3 hides two outputs, the low-latency filter none
  assign sup_limit = (cfg_filt_r == s3ct_pkg::FILT_SINC3) ?
    s3ct_pkg::SINC3_SUPPRESS : 2'h0;

  // delay is picked from the live field, since it is needed on the
  // very edge that takes the start
  assign delay_cnt = 19'(s3ct_pkg::DELAY_TAB[delay_sel]);
  assign period_cnt = 19'(rom_period);

  // overhead is what remains of the first latency after the
  // settling samples; for sinc3 that is three data periods
  assign settle_cnt = 19'(period_cnt * (19'(sup_limit) + 19'h00001));
  assign ovh_cnt = 19'(rom_first - settle_cnt);

  assign done = count_done(cnt_r, mod_tick);
  assign filt_evt = (state_r == s3ct_pkg::S3CT_SAMPLE) && done;

  // a result reaches the host at the end of overhead, or at the end
  // of each later data period in continuous mode
  assign deliver = done &&
    ((state_r == s3ct_pkg::S3CT_OVERHEAD) ||
     (state_r == s3ct_pkg::S3CT_SAMPLE && !first_r));

  // rate table, read after config is latched; the delay phase lasts
  // at least one modulator period so the read data has settled
  s3ct_rate_rom u_rom
  (
    .clk(clk),
    .rst_n(rst_n),
    .filt_sel(cfg_filt_r),
    .rate_idx(rate_clamped),
    .first_r(rom_first),
    .period_r(rom_period)
  );

  // sequencer next state; a start restarts from any state and
  // wins over a stop arriving in the same cycle
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sup_nxt = sup_r;
    first_nxt = first_r;
    div_nxt = adc_tick ? 4'(div_r + 4'h1) : div_r;
    if (start_evt)
    begin
      state_nxt = s3ct_pkg::S3CT_DELAY;
      cnt_nxt = delay_cnt;
      sup_nxt = 2'h0;
      first_nxt = 1'b1;
      div_nxt = 4'h0;
    end
    else if (stop_cmd)
    begin
      state_nxt = s3ct_pkg::S3CT_IDLE;
    end
    else
    begin
      unique case (state_r)
        s3ct_pkg::S3CT_IDLE:
        begin
          cnt_nxt = 19'h00000;
        end
        s3ct_pkg::S3CT_DELAY:
        begin
          if (mod_tick)
            cnt_nxt = 19'(cnt_r - 19'h00001);
          if (done)
          begin
            state_nxt = s3ct_pkg::S3CT_SAMPLE;
            cnt_nxt = period_cnt;
          end
        end
        s3ct_pkg::S3CT_SAMPLE:
        begin
          if (mod_tick)
            cnt_nxt = 19'(cnt_r - 19'h00001);
          if (done)
          begin
            cnt_nxt = period_cnt;
            if (first_r && sup_r < sup_limit)
              sup_nxt = 2'(sup_r + 2'h1);
            else if (first_r)
            begin
              state_nxt = s3ct_pkg::S3CT_OVERHEAD;
              cnt_nxt = ovh_cnt;
            end
          end
        end
        s3ct_pkg::S3CT_OVERHEAD:
        begin
          if (mod_tick)
            cnt_nxt = 19'(cnt_r - 19'h00001);
          if (done)
          begin
            first_nxt = 1'b0;
            cnt_nxt = period_cnt;
            if (cfg_mode_r == s3ct_pkg::MODE_SINGLE)
              state_nxt = s3ct_pkg::S3CT_IDLE;
            else
              state_nxt = s3ct_pkg::S3CT_SAMPLE;
          end
        end
      endcase
    end
  end

  // state and counters
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= s3ct_pkg::S3CT_IDLE;
      cnt_r <= 19'h00000;
      div_r <= 4'h0;
      sup_r <= 2'h0;
      first_r <= 1'b0;
      pin_q_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      sup_r <= sup_nxt;
      first_r <= first_nxt;
      pin_q_r <= start_pin;
    end
  end

  // config is held for the whole run so a mid-run change
  // cannot bend the timing of a conversion in flight
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_mode_r <= s3ct_pkg::MODE_CONT;
      cfg_filt_r <= s3ct_pkg::FILT_SINC3;
      cfg_rate_r <= 4'h0;
    end
    else if (start_evt)
    begin
      cfg_mode_r <= conv_mode;
      cfg_filt_r <= filt_sel;
      cfg_rate_r <= data_rate;
    end
  end

  // registered status and event outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      sampling_r <= 1'b0;
      compensating_r <= 1'b0;
      filt_out_r <= 1'b0;
      new_data_r <= 1'b0;
      sinc3_active_r <= 1'b1;
    end
    else
    begin
      busy_r <= (state_nxt != s3ct_pkg::S3CT_IDLE);
      sampling_r <= (state_nxt == s3ct_pkg::S3CT_SAMPLE);
      compensating_r <= (state_nxt == s3ct_pkg::S3CT_OVERHEAD);
      filt_out_r <= filt_evt && !start_evt && !stop_cmd;
      // suppressed outputs never pulse new data
      new_data_r <= deliver && !start_evt && !stop_cmd;
      sinc3_active_r <= (cfg_filt_r == s3ct_pkg::FILT_SINC3);
    end
  end

endmodule

// >>> dv/s3ct_asserts.sv
// checker on the sequencer ports
// assumes one clock, bound onto s3ct_seq
`timescale 1ns/1ps
module s3ct_asserts
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adc_tick,
  input wire logic start_pin,
  input wire logic start_cmd,
  input wire logic filt_sel,
  input wire logic busy_r,
  input wire logic sampling_r,
  input wire logic compensating_r,
  input wire logic filt_out_r,
  input wire logic new_data_r,
  input wire logic sinc3_active_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // sampling stays low for eight clocks after a command start
  sequence s_delay; !sampling_r [*8]; endsequence
  sequence s_quiet; (!new_data_r && !filt_out_r) [*8]; endsequence
  property p_cmd; start_cmd |=> busy_r; endproperty
  a_cmd: assert property (p_cmd)
    else $error("command start lost");
  property p_pin; $rose(start_pin) |=> busy_r; endproperty
  a_pin: assert property (p_pin)
    else $error("pin start lost");
  property p_delay; start_cmd |=> s_delay; endproperty
  a_delay: assert property (p_delay)
    else $error("sampling without delay");
  property p_quiet; start_cmd |=> s_quiet; endproperty
  a_quiet: assert property (p_quiet)
    else $error("output right after start");
  property p_idle; !busy_r |-> !sampling_r && !compensating_r; endproperty
  a_idle: assert property (p_idle)
    else $error("phase flag while idle");
  property p_nd; new_data_r |=> !new_data_r; endproperty
  a_nd: assert property (p_nd)
    else $error("result pulse too long");
  property p_fo; filt_out_r |=> !filt_out_r; endproperty
  a_fo: assert property (p_fo)
    else $error("filter pulse too long");
  property p_tick;
    new_data_r |-> $past(adc_tick) || $past(adc_tick, 2);
  endproperty
  a_tick: assert property (p_tick)
    else $error("result off the adc tick");
  // the flag follows the latched choice one clock after the latch
  property p_filt;
    start_cmd |=> ##1 (sinc3_active_r == !$past(filt_sel, 2));
  endproperty
  a_filt: assert property (p_filt)
    else $error("filter choice not latched");
  // compensation only ever opens on a filter output
  property p_comp; $rose(compensating_r) |-> filt_out_r; endproperty
  a_comp: assert property (p_comp)
    else $error("compensation without filter output");
  // a result leaves either compensation or a data period
  property p_ndsrc;
    new_data_r |-> $past(compensating_r) || $past(sampling_r);
  endproperty
  a_ndsrc: assert property (p_ndsrc)
    else $error("result from no conversion phase");
endmodule
bind s3ct_seq s3ct_asserts chk_u (.clk(clk), .rst_n(rst_n),
  .adc_tick(adc_tick), .start_pin(start_pin), .start_cmd(start_cmd),
  .filt_sel(filt_sel), .busy_r(busy_r), .sampling_r(sampling_r),
  .compensating_r(compensating_r), .filt_out_r(filt_out_r),
  .new_data_r(new_data_r), .sinc3_active_r(sinc3_active_r));

// >>> dv/s3ct_host.sv
// host model: issues start frames, counts delivered results
// assumes its task is called at a falling clock edge
`timescale 1ns/1ps
module s3ct_host
(
  input wire logic clk,
  input wire logic new_data_r,
  output logic start_cmd,
  output int n_results
);
  initial start_cmd = 1'b0;
  initial n_results = 0;
  // one clock pulse stands for the decoded frame edge
  task send_start;
    start_cmd = 1'b1;
    @(negedge clk);
    start_cmd = 1'b0;
  endtask
  // the host only ever sees settled results
  always @(posedge clk)
    if (new_data_r === 1'b1)
      n_results <= n_results + 1;
endmodule

// >>> dv/tb_s3ct_seq.sv
// bench for the sinc3 timing sequencer
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb_s3ct_seq;
  typedef struct {int c; int nf;} s3ct_exp_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic adc_tick = 1'b1;
  logic start_pin = 1'b0;
  logic stop_cmd = 1'b0;
  logic conv_mode = 1'b1;
  logic filt_sel = 1'b0;
  logic [3:0] data_rate = 4'hD;
  logic [2:0] delay_sel = 3'h0;
  logic start_cmd, busy_r, sampling_r, compensating_r;
  logic filt_out_r, new_data_r, sinc3_active_r;
  int n_results;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  int nfilt = 0;
  int div = 1;
  int tph = 0;
  int f3 [0:2] = '{808, 424, 232};
  int fl [0:2] = '{296, 168, 104};
  int per [0:2] = '{256, 128, 64};
  s3ct_exp_t q[$];
  always #4 clk = ~clk;
  // div 2 stands for a halved adc clock
  always @(negedge clk)
  begin
    tph = (tph + 1) % div;
    adc_tick <= (tph == 0);
  end
  s3ct_seq dut_u (.clk(clk), .rst_n(rst_n), .adc_tick(adc_tick),
    .start_pin(start_pin), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
    .conv_mode(conv_mode), .filt_sel(filt_sel), .data_rate(data_rate),
    .delay_sel(delay_sel), .busy_r(busy_r), .sampling_r(sampling_r),
    .compensating_r(compensating_r), .filt_out_r(filt_out_r),
    .new_data_r(new_data_r), .sinc3_active_r(sinc3_active_r));
  s3ct_host host_u (.clk(clk), .new_data_r(new_data_r),
    .start_cmd(start_cmd), .n_results(n_results));
  task wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task fail(string m);
    miscompares++;
    $display("ERROR %0t %s", $time, m);
  endtask
  task check_bit(logic got, logic exp, string m);
    n_compared++;
    if (got !== exp)
      fail(m);
  endtask
  // time window covers tick alignment and output registers
  task check_res(s3ct_exp_t x);
    n_compared += 2;
    if (cyc < x.c || cyc > x.c + 3)
      fail("result time");
    if (nfilt != x.nf)
      fail("filter outputs before result");
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (filt_out_r === 1'b1)
      nfilt = nfilt + 1;
    if (new_data_r === 1'b1 && q.size() == 0)
      fail("unexpected result");
    else if (new_data_r === 1'b1)
    begin
      check_res(q.pop_front());
      nfilt = 0;
    end
  end
  task kick(logic pin);
    if (pin)
    begin
      start_pin = 1'b1;
      @(negedge clk);
      start_pin = 1'b0;
    end
    else
      host_u.send_start();
  endtask
  // mode 1 single, filt 1 low-latency, ds 0 or 7
  task run(logic pin, logic mode, logic filt, int r, logic [2:0] ds,
    int nres, bit restart);
    s3ct_exp_t x;
    int c0;
    int i;
    conv_mode = mode;
    filt_sel = filt;
    data_rate = r[3:0];
    delay_sel = ds;
    if (restart)
      kick(pin);
    repeat (restart ? 300 : 0) @(negedge clk);
    c0 = cyc + 1;
    nfilt = 0;
    kick(pin);
    // config changes while running must be ignored
    data_rate = 4'($urandom);
    filt_sel = ~filt;
    for (i = 0; i < nres; i++)
    begin
      x.c = (ds == 3'h0 ? 14 : 1) + (filt ? fl[r - 11] : f3[r - 11]);
      x.c = c0 + (x.c + i * per[r - 11]) * 16 * div;
      x.nf = (i == 0 && !filt) ? 3 : 1;
      q.push_back(x);
    end
    for (i = 0; i < 40000 && q.size() > 0; i++) @(negedge clk);
    if (q.size() > 0)
    begin
      fail("timeout");
      wrap_up();
    end
    repeat (2) @(negedge clk);
    check_bit(busy_r, ~mode, "busy after result");
    check_bit(sinc3_active_r, ~filt, "filter flag");
    stop_cmd = 1'b1;
    @(negedge clk);
    stop_cmd = 1'b0;
    repeat (30) @(negedge clk);
    check_bit(busy_r, 1'b0, "busy after stop");
    $display("test done at %0t", $time);
  endtask
  initial
  begin
    void'($urandom(97));
    repeat (2) @(negedge clk);
    check_bit(sinc3_active_r, 1'b1, "reset filter flag");
    check_bit(busy_r, 1'b0, "reset busy");
    rst_n = 1'b1;
    run(1'b0, 1'b1, 1'b0, 13, 3'h7, 1, 1'b0);
    run(1'b1, 1'b0, 1'b0, 13, 3'h0, 3, 1'b0);
    run(1'b0, 1'b1, 1'b1, 13, 3'h7, 1, 1'b0);
    div = 2;
    run(1'b0, 1'b1, 1'b0, 11 + $urandom % 3, 3'h7, 1, 1'b1);
    run(1'b1, 1'b0, 1'b1, 11 + $urandom % 3, 3'h7, 2, 1'b0);
    check_bit(n_results == 8, 1'b1, "host result count");
    wrap_up();
  end
endmodule
